// ==== nis_cfg.svh ====
// constants for the interrupt status and enable block
//
// What this block does
// [RULE_01] a receive flag clears only on a written one; zeros leave it
// [RULE_02] receive flags are set by internal events only, never by writes
// [RULE_03] clearing a flag drops its interrupt contribution at once
// [RULE_04] host service reads all flags and handles every set one
// [RULE_05] host writes back what it read instead of all ones
// [RULE_06] bit 7 sets when a received packet is stored in the buffer
// [RULE_07] bit 6 sets when a host read waits 2.4 us without ready
// [RULE_08] bit 5 sets on dma end input and blocks the dma request
// [RULE_09] bit 5 clears when zero is written to the dma mode register
// [RULE_10] bit 4 sets when the length/type field reads 0900h, msb first
// [RULE_11] bit 3 sets when a frame is shorter than 60 bytes
// [RULE_12] bit 2 sets when a frame ends with one to seven extra bits
// [RULE_13] bit 1 sets when a frame fails its crc check
// [RULE_14] bit 0 sets on buffer-full rejection, never in loopback
// [RULE_15] only transmit mask bits 7, 2 and 1 exist; others read zero
// [RULE_16] each receive mask bit enables the receive flag at its position
// [RULE_17] transmit-complete sets when the whole transmit buffer is done
// [RULE_18] excess collision sets on the 16th failure; collision on any
// [RULE_19] interrupt is high while any flag meets its mask bit
// [RULE_20] reset clears all flags and all mask bits
`ifndef NIS_CFG_SVH
`define NIS_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define NIS_OFF_TX_FLAGS 8'h00
`define NIS_OFF_RX_FLAGS 8'h04
`define NIS_OFF_TX_MASK 8'h08
`define NIS_OFF_RX_MASK 8'h0C
`define NIS_OFF_DMA_MODE 8'h10

// ----------------------------------------------------------------
// fields and values
// ----------------------------------------------------------------
`define NIS_TX_DONE_BIT 7
`define NIS_TX_COL_BIT 2
`define NIS_TX_XCOL_BIT 1
`define NIS_TX_IMPL 8'h86
`define NIS_PACKET_STORED_FLAG_BIT 7
`define NIS_RX_TMO_BIT 6
`define NIS_RX_DMA_BIT 5
`define NIS_RX_RMT_BIT 4
`define NIS_RX_RUNT_BIT 3
`define NIS_RX_ALIGN_BIT 2
`define NIS_RX_CRC_BIT 1
`define NIS_RX_OVF_BIT 0
`define NIS_BYTE_ZERO 8'h00
`define NIS_WORD_ZERO 32'h0000_0000
`define NIS_REMOTE_TYPE 16'h0900
`define NIS_TYPE_HI_IDX 11'h00C
`define NIS_TYPE_LO_IDX 11'h00D
`define NIS_RUNT_LEN 11'h03C
`define NIS_LEN_MAX 11'h7FF
`define NIS_COL_LIMIT 5'h10

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define NIS_CLK_MHZ 25
`define NIS_RD_TMO_NS 2400
`define NIS_RD_TMO_CYC ((`NIS_RD_TMO_NS * `NIS_CLK_MHZ) / 1000)

`endif

// ==== nis_host_model.sv ====
// host-side model of dma controller and bus-ready source for the block
`timescale 1ns/1ps
`default_nettype none
module nis_host_model (
   input wire logic ref_clk_i,
   input wire logic rd_strobe_i,
   input wire logic [7:0] ready_dly_i,
   input wire logic eop_go_i,
   input wire logic req_en_i,
   output logic rd_ready_o,
   output logic eop_o,
   output logic dma_req_o
);
   logic [7:0] wait_cnt = 8'h00;
   logic [1:0] eop_cnt = 2'h0;
   // ----------------------------------------------------------------
   // data read ready
   // ----------------------------------------------------------------
   // a zero delay stands for an empty buffer: ready never comes
   always_ff @(posedge ref_clk_i) begin
      wait_cnt <= rd_strobe_i ? wait_cnt + 8'h01 : 8'h00;
   end
   assign rd_ready_o = rd_strobe_i && ready_dly_i != 8'h00 &&
                       wait_cnt >= ready_dly_i;
   // ----------------------------------------------------------------
   // dma end pin and request level
   // ----------------------------------------------------------------
   // end pin held two cycles so the 2-flop synchroniser cannot miss it
   always_ff @(posedge ref_clk_i) begin
      if (eop_go_i) begin
         eop_cnt <= 2'h2;
      end else if (eop_cnt != 2'h0) begin
         eop_cnt <= eop_cnt - 2'h1;
      end
   end
   assign eop_o = eop_cnt != 2'h0;
   assign dma_req_o = req_en_i;
endmodule
`default_nettype wire

// ==== nis_irq.sv ====
// status flags, interrupt masks and apb slave of the network controller
`timescale 1ns/1ps
`default_nettype none
`include "nis_cfg.svh"

module nis_irq
   import nis_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // receive path
   input wire logic rx_byte_valid_i,
   input wire logic [7:0] rx_byte_i,
   input wire logic rx_frame_end_i,
   input wire logic [2:0] rx_extra_bits_i,
   input wire logic rx_crc_bad_i,
   input wire logic packet_stored_flag_stored_i,
   input wire logic rx_ring_reject_i,
   input wire logic loopback_i,
   // host data read strobe from the bus interface
   input wire logic rd_strobe_i,
   input wire logic rd_ready_i,
   // dma
   input wire logic dma_terminal_input_i,
   input wire logic dma_req_i,
   output logic dma_request_output_o,
   // transmit path
   input wire logic tx_pkt_start_i,
   input wire logic tx_collision_i,
   input wire logic tx_buffer_done_i,
   // merged interrupt
   output logic irq_o
);

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   localparam nis_tmo_t TMO_CYC = nis_tmo_t'(`NIS_RD_TMO_CYC);

   nis_byte_t tx_flags;
   nis_byte_t rx_flags;
   nis_byte_t tx_mask;
   nis_byte_t rx_mask;
   nis_byte_t dma_mode;
   logic rd_ok;
   logic hit;
   logic wr_en;
   logic hit_txf, hit_rxf, hit_txm, hit_rxm, hit_dma;
   nis_byte_t wbyte;
   nis_byte_t rd_mux;

   assign hit_txf = (paddr_i == `NIS_OFF_TX_FLAGS);
   assign hit_rxf = (paddr_i == `NIS_OFF_RX_FLAGS);
   assign hit_txm = (paddr_i == `NIS_OFF_TX_MASK);
   assign hit_rxm = (paddr_i == `NIS_OFF_RX_MASK);
   assign hit_dma = (paddr_i == `NIS_OFF_DMA_MODE);
   assign hit = hit_txf | hit_rxf | hit_txm | hit_rxm | hit_dma;
   assign wbyte = pwdata_i[7:0];

   // read data is caught in the setup cycle of a transfer, so
   // the answer comes in the first access cycle without a wait state
   assign pready_o = psel_i & penable_i & rd_ok & ce_i;
   assign pslverr_o = pready_o & ~hit;
   assign wr_en = pready_o & pwrite_i & hit;

   always_comb begin
      rd_mux = `NIS_BYTE_ZERO;
      unique case (1'b1)
         hit_txf: rd_mux = tx_flags;
         hit_rxf: rd_mux = rx_flags;
         hit_txm: rd_mux = tx_mask;
         hit_rxm: rd_mux = rx_mask;
         hit_dma: rd_mux = dma_mode;
         default: rd_mux = `NIS_BYTE_ZERO;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         rd_ok <= 1'b0;
      end else if (ce_i) begin
         rd_ok <= psel_i & ~pready_o;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         prdata_o <= `NIS_WORD_ZERO;
      end else if (ce_i && psel_i && !rd_ok) begin
         prdata_o <= {24'h00_0000, rd_mux};
      end
   end

   // ----------------------------------------------------------------
   // mask and dma mode registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         tx_mask <= `NIS_BYTE_ZERO; // [RULE_20]
         rx_mask <= `NIS_BYTE_ZERO; // [RULE_20]
         dma_mode <= `NIS_BYTE_ZERO;
      end else if (ce_i && wr_en) begin
         if (hit_txm) begin
            tx_mask <= wbyte & `NIS_TX_IMPL; // [RULE_15]
         end
         if (hit_rxm) begin
            rx_mask <= wbyte; // [RULE_16]
         end
         if (hit_dma) begin
            dma_mode <= wbyte;
         end
      end
   end

   // ----------------------------------------------------------------
   // receive frame parsing
   // ----------------------------------------------------------------
   nis_len_t rx_len;
   logic [15:0] rx_type;

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         rx_len <= 11'h000;
         rx_type <= 16'h0000;
      end else if (ce_i) begin
         if (rx_frame_end_i) begin
            rx_len <= 11'h000;
         end else if (rx_byte_valid_i) begin
            if (rx_len != `NIS_LEN_MAX) begin
               rx_len <= rx_len + 11'h001;
            end
            if (rx_len == `NIS_TYPE_HI_IDX) begin
               rx_type[15:8] <= rx_byte_i; // [RULE_10]
            end
            if (rx_len == `NIS_TYPE_LO_IDX) begin
               rx_type[7:0] <= rx_byte_i; // [RULE_10]
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // host read timeout
   // ----------------------------------------------------------------
   nis_tmo_t rd_cnt;
   logic rd_tmo_ev;

   assign rd_tmo_ev = rd_strobe_i & ~rd_ready_i &
                      (rd_cnt == TMO_CYC - nis_tmo_t'(1)); // [RULE_07]

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         rd_cnt <= 7'h00;
      end else if (ce_i) begin
         if (!rd_strobe_i || rd_ready_i) begin
            rd_cnt <= 7'h00;
         end else if (rd_cnt != TMO_CYC) begin
            rd_cnt <= rd_cnt + 7'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // dma end input, a pin from another clock domain
   // ----------------------------------------------------------------
   logic eop_s1, eop_s2, eop_s3;
   logic eop_ev;

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         eop_s1 <= 1'b0;
         eop_s2 <= 1'b0;
         eop_s3 <= 1'b0;
      end else if (ce_i) begin
         eop_s1 <= dma_terminal_input_i;
         eop_s2 <= eop_s1;
         eop_s3 <= eop_s2;
      end
   end

   assign eop_ev = eop_s2 & ~eop_s3; // [RULE_08]

   // ----------------------------------------------------------------
   // receive status flags
   // ----------------------------------------------------------------
   nis_byte_t rx_set;
   nis_byte_t rx_clr;
   logic dma_zero_wr;

   assign dma_zero_wr = wr_en & hit_dma & (wbyte == `NIS_BYTE_ZERO);

   always_comb begin
      rx_set = `NIS_BYTE_ZERO;
      rx_set[`NIS_PACKET_STORED_FLAG_BIT] = packet_stored_flag_stored_i; // [RULE_06]
      rx_set[`NIS_RX_TMO_BIT] = rd_tmo_ev; // [RULE_07]
      rx_set[`NIS_RX_DMA_BIT] = eop_ev; // [RULE_08]
      rx_set[`NIS_RX_RMT_BIT] = rx_frame_end_i &
         (rx_len > `NIS_TYPE_LO_IDX) &
         (rx_type == `NIS_REMOTE_TYPE); // [RULE_10]
      rx_set[`NIS_RX_RUNT_BIT] = rx_frame_end_i &
         (rx_len < `NIS_RUNT_LEN); // [RULE_11]
      rx_set[`NIS_RX_ALIGN_BIT] = rx_frame_end_i &
         (rx_extra_bits_i != 3'h0); // [RULE_12]
      rx_set[`NIS_RX_CRC_BIT] = rx_frame_end_i & rx_crc_bad_i; // [RULE_13]
      rx_set[`NIS_RX_OVF_BIT] = rx_ring_reject_i & ~loopback_i; // [RULE_14]
   end

   always_comb begin
      rx_clr = (wr_en & hit_rxf) ? wbyte : `NIS_BYTE_ZERO; // [RULE_01]
      rx_clr[`NIS_RX_DMA_BIT] = rx_clr[`NIS_RX_DMA_BIT] |
         dma_zero_wr; // [RULE_09]
   end

   // an event in the clearing cycle is kept: set wins over clear
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         rx_flags <= `NIS_BYTE_ZERO; // [RULE_20]
      end else if (ce_i) begin
         rx_flags <= (rx_flags & ~rx_clr) | rx_set; // [RULE_02]
      end
   end

   // ----------------------------------------------------------------
   // transmit status flags
   // ----------------------------------------------------------------
   nis_col_t col_cnt;
   nis_byte_t tx_set;
   nis_byte_t tx_clr;

   // collisions count per packet; a new packet starts the count again
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         col_cnt <= 5'h00;
      end else if (ce_i) begin
         if (tx_pkt_start_i) begin
            col_cnt <= 5'h00;
         end else if (tx_collision_i && col_cnt != `NIS_COL_LIMIT) begin
            col_cnt <= col_cnt + 5'h01;
         end
      end
   end

   always_comb begin
      tx_set = `NIS_BYTE_ZERO;
      tx_set[`NIS_TX_DONE_BIT] = tx_buffer_done_i; // [RULE_17]
      tx_set[`NIS_TX_COL_BIT] = tx_collision_i; // [RULE_18]
      tx_set[`NIS_TX_XCOL_BIT] = tx_collision_i & ~tx_pkt_start_i &
         (col_cnt == `NIS_COL_LIMIT - 5'h01); // [RULE_18]
      tx_clr = (wr_en & hit_txf) ? wbyte : `NIS_BYTE_ZERO;
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         tx_flags <= `NIS_BYTE_ZERO;
      end else if (ce_i) begin
         tx_flags <= ((tx_flags & ~tx_clr) | tx_set) & `NIS_TX_IMPL;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // combinational from the flags, so a clear drops the request with it
   assign irq_o = |(tx_flags & tx_mask) |
      |(rx_flags & rx_mask); // [RULE_19] [RULE_03]
   assign dma_request_output_o = dma_req_i &
      ~rx_flags[`NIS_RX_DMA_BIT]; // [RULE_08]

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   w1c_clear_a: assert property ( // [RULE_01]
      ce_i && wr_en && hit_rxf && wbyte[`NIS_RX_CRC_BIT] &&
      !rx_set[`NIS_RX_CRC_BIT] |=> !rx_flags[`NIS_RX_CRC_BIT])
      else $error("crc flag not cleared by written one");

   no_host_set_a: assert property ( // [RULE_02]
      ce_i && !rx_set[`NIS_PACKET_STORED_FLAG_BIT] && !rx_flags[`NIS_PACKET_STORED_FLAG_BIT]
      |=> !rx_flags[`NIS_PACKET_STORED_FLAG_BIT])
      else $error("packet flag set without an event");

   irq_drop_a: assert property ( // [RULE_03]
      ce_i && rx_flags == 8'h01 && tx_flags == 8'h00 && wr_en &&
      hit_rxf && wbyte == 8'h01 && rx_set == 8'h00 |=> !irq_o)
      else $error("interrupt survived its only flag clearing");

   rd_timeout_a: assert property ( // [RULE_07]
      ce_i && rd_strobe_i && !rd_ready_i && rd_cnt == 7'h00 &&
      !rx_flags[`NIS_RX_TMO_BIT] ##1 (ce_i && rd_strobe_i &&
      !rd_ready_i)[*8] |-> !rx_flags[`NIS_RX_TMO_BIT])
      else $error("read timeout flag set too early");

   dma_block_a: assert property ( // [RULE_08]
      rx_flags[`NIS_RX_DMA_BIT] |-> !dma_request_output_o)
      else $error("dma request while dma done flag set");

   dma_zero_a: assert property ( // [RULE_09]
      ce_i && dma_zero_wr && !eop_ev |=> !rx_flags[`NIS_RX_DMA_BIT])
      else $error("dma done flag kept after zero mode write");

   runt_flag_a: assert property ( // [RULE_11]
      ce_i && rx_frame_end_i && rx_len < `NIS_RUNT_LEN
      |=> rx_flags[`NIS_RX_RUNT_BIT])
      else $error("short frame did not raise its flag");

   ovf_loop_a: assert property ( // [RULE_14]
      ce_i && loopback_i && !rx_flags[`NIS_RX_OVF_BIT]
      |=> !rx_flags[`NIS_RX_OVF_BIT])
      else $error("overflow flag set in loopback");

   tx_mask_a: assert property ( // [RULE_15]
      $past(ce_i && wr_en && hit_txm) |-> (tx_mask & ~`NIS_TX_IMPL) == 8'h00)
      else $error("reserved transmit mask bit stored");

   irq_merge_a: assert property ( // [RULE_19]
      irq_o == ((|(rx_flags & rx_mask)) || (|(tx_flags & tx_mask))))
      else $error("interrupt does not match flags and masks");

   excess_col_a: assert property ( // [RULE_18]
      ce_i && tx_collision_i && !tx_pkt_start_i && col_cnt == 5'h0F
      |=> tx_flags[`NIS_TX_XCOL_BIT])
      else $error("sixteenth collision did not raise excess flag");

endmodule
`default_nettype wire

// ==== nis_irq_tb_top.sv ====
// self-checking testbench of the status, mask and interrupt block
`timescale 1ns/1ps
`default_nettype none
module nis_irq_tb_top;
   import nis_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, rbyte = 8'h00, ready_dly = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, perr, rd_ready, eop, dma_req, dma_request_output_out, irq;
   logic bvalid = 1'b0, fend = 1'b0, crc_bad = 1'b0, loopback = 1'b0;
   logic rd_strobe = 1'b0, req_en = 1'b0, ce = 1'b1, c;
   logic [5:0] ev = 6'h00;
   logic [2:0] extra = 3'h0, x;
   logic [7:0] exp_f, m;
   logic [15:0] ty;
   int err_count = 0, check_count = 0, len;

   nis_irq i_nis_irq (.ref_clk_i(clk), .reset_i(rst), .ce_i(ce),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .rx_byte_valid_i(bvalid),
      .rx_byte_i(rbyte), .rx_frame_end_i(fend), .rx_extra_bits_i(extra),
      .rx_crc_bad_i(crc_bad), .packet_stored_flag_stored_i(ev[0]),
      .rx_ring_reject_i(ev[1]), .loopback_i(loopback),
      .rd_strobe_i(rd_strobe), .rd_ready_i(rd_ready),
      .dma_terminal_input_i(eop), .dma_req_i(dma_req),
      .dma_request_output_o(dma_request_output_out), .tx_pkt_start_i(ev[3]),
      .tx_collision_i(ev[4]), .tx_buffer_done_i(ev[5]), .irq_o(irq));
   nis_host_model i_nis_host_model (.ref_clk_i(clk),
      .rd_strobe_i(rd_strobe), .ready_dly_i(ready_dly), .eop_go_i(ev[2]),
      .req_en_i(req_en), .rd_ready_o(rd_ready), .eop_o(eop),
      .dma_req_o(dma_req));

   // ----------------------------------------------------------------
   // shared tasks and expectations
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk);
      end
      chk("pready", 32'h0000_0001, {31'h0, pready});
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pulse(input int k);
      @(posedge clk);
      ev[k] <= 1'b1;
      @(posedge clk);
      ev[k] <= 1'b0;
   endtask
   task automatic frame(input int n, input logic [15:0] t,
                        input logic [2:0] e, input logic bad);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         bvalid <= 1'b1;
         rbyte <= i == 12 ? t[15:8] : (i == 13 ? t[7:0] : 8'($urandom));
      end
      @(posedge clk);
      bvalid <= 1'b0;
      fend <= 1'b1;
      extra <= e;
      crc_bad <= bad;
      @(posedge clk);
      fend <= 1'b0;
      crc_bad <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   function automatic logic [7:0] frame_flags(int n, logic [15:0] t,
                                              logic [2:0] e, logic bad);
      return {3'h0, n >= 14 && t == 16'h0900, n < 60, e != 3'h0, bad, 1'b0};
   endfunction
   task automatic give_verdict();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // clock, watchdog and tests
   // ----------------------------------------------------------------
   initial begin
      forever #20 clk = ~clk;
   end
   // the whole run takes about 1300 cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'h566c_5f0b));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 6; a++) begin
         apb(1'b0, 8'(a * 4), 32'h0000_0000);
         chk("reset value", 32'h0000_0000, rd);
         chk("slverr", {31'h0, a == 5}, {31'h0, perr});
      end
      repeat (4) begin
         m = 8'($urandom);
         apb(1'b1, 8'h08, {24'h0, m});
         apb(1'b0, 8'h08, 32'h0000_0000);
         chk("tx mask", {24'h0, m & 8'h86}, rd);
         apb(1'b1, 8'h10, {24'h0, m});
         apb(1'b0, 8'h10, 32'h0000_0000);
         chk("dma mode", {24'h0, m}, rd);
      end
      apb(1'b1, 8'h08, 32'h0000_0000);
      for (int k = 0; k < 12; k++) begin
         len = k < 2 ? 59 + k : 10 + $urandom_range(0, 65);
         ty = $urandom_range(0, 1) ? 16'h0900 : 16'($urandom);
         x = $urandom_range(0, 1) ? 3'($urandom) : 3'h0;
         c = 1'($urandom);
         m = 8'($urandom);
         apb(1'b1, 8'h0C, {24'h0, m});
         apb(1'b0, 8'h0C, 32'h0000_0000);
         chk("rx mask", {24'h0, m}, rd);
         frame(len, ty, x, c);
         exp_f = frame_flags(len, ty, x, c);
         apb(1'b0, 8'h04, 32'h0000_0000);
         chk("rx flags", {24'h0, exp_f}, rd);
         chk("remote flag", {31'h0, exp_f[4]}, {31'h0, rd[4]});
         chk("runt flag", {31'h0, exp_f[3]}, {31'h0, rd[3]});
         chk("align flag", {31'h0, exp_f[2]}, {31'h0, rd[2]});
         chk("crc flag", {31'h0, exp_f[1]}, {31'h0, rd[1]});
         chk("irq", {31'h0, |(exp_f & m)}, {31'h0, irq});
         apb(1'b1, 8'h04, 32'h0000_0000);
         apb(1'b0, 8'h04, 32'h0000_0000);
         chk("rx flags kept", {24'h0, exp_f}, rd);
         apb(1'b1, 8'h04, rd);
         @(negedge clk);
         chk("irq after clear", 32'h0000_0000, {31'h0, irq});
         apb(1'b0, 8'h04, 32'h0000_0000);
         chk("rx flags cleared", 32'h0000_0000, rd);
      end
      // an event while the enable is low is lost, as all state is frozen
      ce <= 1'b0;
      pulse(0);
      ce <= 1'b1;
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk("frozen event", 32'h0000_0000, rd);
      pulse(0);
      pulse(1);
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk("stored and reject", 32'h0000_0081, rd);
      apb(1'b1, 8'h04, 32'h0000_0080);
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk("single clear", 32'h0000_0001, rd);
      apb(1'b1, 8'h04, rd);
      loopback <= 1'b1;
      pulse(1);
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk("loopback reject", 32'h0000_0000, rd);
      loopback <= 1'b0;
      // ready in time, short wait, then an empty-buffer read
      for (int k = 0; k < 3; k++) begin
         ready_dly <= k == 0 ? 8'h1E : 8'h00;
         rd_strobe <= 1'b1;
         repeat (k == 1 ? 58 : 70) @(posedge clk);
         rd_strobe <= 1'b0;
         apb(1'b0, 8'h04, 32'h0000_0000);
         chk("read timeout", k == 2 ? 32'h0000_0040 : 32'h0, rd);
         apb(1'b1, 8'h04, rd);
      end
      req_en <= 1'b1;
      @(negedge clk);
      chk("dma request", 32'h0000_0001, {31'h0, dma_request_output_out});
      pulse(2);
      repeat (6) @(posedge clk);
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk("dma done", 32'h0000_0020, rd);
      chk("dma request held", 32'h0000_0000, {31'h0, dma_request_output_out});
      apb(1'b1, 8'h10, 32'h0000_0000);
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk("dma flag cleared", 32'h0000_0000, rd);
      chk("dma request back", 32'h0000_0001, {31'h0, dma_request_output_out});
      apb(1'b1, 8'h08, 32'h0000_0086);
      for (int n = 15; n < 17; n++) begin
         pulse(3);
         repeat (n) pulse(4);
         apb(1'b0, 8'h00, 32'h0000_0000);
         chk("collisions", n == 16 ? 32'h6 : 32'h4, rd);
         chk("tx irq", 32'h0000_0001, {31'h0, irq});
         apb(1'b1, 8'h00, rd);
      end
      apb(1'b1, 8'h08, 32'h0000_0006);
      pulse(5);
      @(negedge clk);
      chk("masked done", 32'h0000_0000, {31'h0, irq});
      apb(1'b1, 8'h08, 32'h0000_0086);
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk("tx done", 32'h0000_0080, rd);
      chk("done irq", 32'h0000_0001, {31'h0, irq});
      apb(1'b1, 8'h00, 32'h0000_0080);
      @(negedge clk);
      chk("done cleared", 32'h0000_0000, {31'h0, irq});
      give_verdict();
   end
endmodule
`default_nettype wire

// ==== nis_pkg.sv ====
// types shared by the interrupt status and enable block
package nis_pkg;
   typedef logic [7:0] nis_byte_t;
   typedef logic [10:0] nis_len_t;
   typedef logic [4:0] nis_col_t;
   typedef logic [6:0] nis_tmo_t;
endpackage
